// ### core/rip_cfg.svh
`ifndef RIP_CFG_SVH
`define RIP_CFG_SVH

`define RIP_OFS_MISC       16'h103c
`define RIP_OFS_CTRL       16'h1040
`define RIP_OFS_LOCAL_EN   16'h1044
`define RIP_OFS_STATUS     16'h1048
`define RIP_OFS_CLEAR      16'h104c
`define RIP_OFS_INT_EN     16'h1050

`define RIP_MISC_BROM      7
`define RIP_MISC_SPCL      6
`define RIP_MISC_MSEL_A    5
`define RIP_MISC_VIS       4
`define RIP_PSEL_RESET     4'h6
`define RIP_PSEL_RSVD      4'h5

`define RIP_CTRL_CMON      0
`define RIP_CTRL_WDOG_DIS  1

`define RIP_EN_RX          16
`define RIP_EN_TX          17
`define RIP_EN_TXDN        18
`define RIP_EN_IDLE        19

`define RIP_ST_REFUSED     0
`define RIP_ST_RX_CLR      1
`define RIP_ST_NEW_REQ     2

`define RIP_NUM_MASKABLE   15
`define RIP_SRC_RESET      5'h0f
`define RIP_SRC_CLKMON     5'h10
`define RIP_SRC_WDOG       5'h11
`define RIP_SRC_NMPN       5'h12
`define RIP_SRC_ILLOP      5'h13
`define RIP_SRC_TRAP       5'h14

`define RIP_VEC_RESET      16'hfffe
`define RIP_VEC_CLKMON     16'hfffc
`define RIP_VEC_WDOG       16'hfffa
`define RIP_VEC_ILLOP      16'hfff8
`define RIP_VEC_TRAP       16'hfff6
`define RIP_VEC_NMPN       16'hfff4
`define RIP_VEC_MASK_TOP   16'hfff2

`define RIP_RESP_OKAY      2'h0
`define RIP_RESP_SLVERR    2'h2

`endif

// ### core/rip_mask_arb.sv
`timescale 1ns/1ns
module rip_mask_arb import rip_pkg::*; #(
  parameter int N = 15
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] pend,
  input  wire logic [3:0]   top_idx,
  output logic              hit,
  output logic [3:0]        idx
);

  always_comb begin
    hit = |pend;
    idx = 4'h0;
    for (int k = N - 1; k >= 0; k--) begin
      if (pend[k]) begin
        idx = 4'(k);
      end
    end
    if (pend[top_idx]) begin
      idx = top_idx;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_promoted_wins: assert property (pend[top_idx] |-> idx == top_idx)
    else $error("promoted source not chosen");
  a_default_order: assert property (
    hit && !pend[top_idx] |-> pend[idx] && ((pend & ((N)'(1) << idx) - (N)'(1)) == '0))
    else $error("default maskable order broken");
  a_hit_pending: assert property (hit |-> pend[idx])
    else $error("chosen source not pending");

endmodule

// ### core/rip_pkg.sv
`include "rip_cfg.svh"

package rip_pkg;

  typedef struct packed {
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  misc;
    logic        captured;
    logic [1:0]  ctrl;
    logic [19:0] local_en;
    logic [2:0]  status;
    logic [2:0]  int_en;
    logic        req_valid;
    logic        req_nonmask;
    logic [4:0]  req_src;
    logic [15:0] req_vector;
  } rip_state_t;

  typedef struct packed {
    logic full;
    logic armed;
  } rip_rx_state_t;

  // Promotion field to default-order index
  function automatic logic [3:0] rip_psel_to_idx(input logic [3:0] psel);
    logic [3:0] idx;
    idx = 4'h0;
    unique case (psel)
      4'h0: idx = 4'ha;
      4'h1: idx = 4'hb;
      4'h2: idx = 4'hc;
      4'h3: idx = 4'hd;
      4'h4: idx = 4'he;
      4'h5: idx = 4'h0;
      4'h6: idx = 4'h0;
      4'h7: idx = 4'h1;
      default: idx = psel - 4'h6;
    endcase
    return idx;
  endfunction

  // Fixed vector of every source, independent of promotion
  function automatic logic [15:0] rip_vector_of(input logic [4:0] src);
    logic [15:0] v;
    v = `RIP_VEC_MASK_TOP - {10'h000, src, 1'b0};
    unique case (src)
      `RIP_SRC_RESET:  v = `RIP_VEC_RESET;
      `RIP_SRC_CLKMON: v = `RIP_VEC_CLKMON;
      `RIP_SRC_WDOG:   v = `RIP_VEC_WDOG;
      `RIP_SRC_NMPN:   v = `RIP_VEC_NMPN;
      `RIP_SRC_ILLOP:  v = `RIP_VEC_ILLOP;
      `RIP_SRC_TRAP:   v = `RIP_VEC_TRAP;
      default:         v = `RIP_VEC_MASK_TOP - {10'h000, src, 1'b0};
    endcase
    return v;
  endfunction

  function automatic logic [31:0] rip_apply_be(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ### core/rip_resolver.sv
// How it works
// - Non-maskable order: reset, clock monitor, watchdog, nonmaskable pin, illegal op, trap.
// - Fifteen maskable sources ranked external pin first down to serial comms.
// - Priority select field lifts one maskable source above the rest.
// - A lifted source still obeys the global mask and its local enables.
// - Promotion never alters the vector of any source.
// - Priority select writes accepted only while the global mask is set.
// - Select codes map to sources; reserved code acts as external pin.
// - Reset loads select with the external pin code.
// - Boot ROM bit reads zero and ignores writes unless special mode.
// - Special mode bit captures inverted mode-B pin at reset release.
// - Mode-A bit captures the mode-A pin at reset release.
// - Upper nibble reset value follows mode; low nibble resets to six.
// - Visibility bit drives read visibility or bus clock output by mode.
// - Twenty-five sources share twenty-one vectors; serial comms sources share one.
// - Each source owns a fixed two-byte vector address.
// - Maskable need clear global mask; pin obeys own mask; others ignore both.
// - Local enables gate peripherals and serial comms; watchdog and clock monitor are gated by the control register.
// - Receive flag clears on status read then data read.
`timescale 1ns/1ns
module rip_resolver import rip_pkg::*; #(
  parameter int ADDR_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              mode_select_a_pin,
  input  wire logic              mode_select_b_pin,
  input  wire logic              cnd_i_mask,
  input  wire logic              cnd_x_mask,
  input  wire logic              reset_req,
  input  wire logic              clock_monitor_fail,
  input  wire logic              watchdog_reset,
  input  wire logic              nonmaskable_request_pin_n,
  input  wire logic              illegal_opcode,
  input  wire logic              software_trap,
  input  wire logic              irq_pin_n,
  input  wire logic [12:0]       periph_flag,
  input  wire logic              ser_rx_set,
  input  wire logic              ser_status_rd,
  input  wire logic              ser_data_rd,
  input  wire logic              ser_overrun,
  input  wire logic              ser_tx_empty,
  input  wire logic              ser_tx_done,
  input  wire logic              ser_idle,
  output logic                   receive_full_flag,
  output logic                   req_valid,
  output logic                   req_nonmask,
  output logic [4:0]             req_src,
  output logic [15:0]            req_vector,
  output logic                   read_visibility_only,
  output logic                   bus_clock_out_en,
  output logic                   boot_rom_read,
  output logic                   special_mode_flag,
  output logic                   mode_a_flag,
  output logic                   irq_out
);

  rip_state_t s_q;
  rip_state_t s_d;

  logic        wr_go;
  logic        rd_go;
  logic        wr_misc;
  logic [14:0] m_pend;
  logic [14:0] m_qual;
  logic        m_hit;
  logic [3:0]  m_idx;
  logic [5:0]  nm_qual;
  logic        ser_any;
  logic        rx_auto_clr;
  logic [3:0]  top_idx;
  logic [1:0]  ev;
  logic [31:0] local_en_wr;
  logic        psel_refused;

  assign wr_go   = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign rd_go   = s_axi_arvalid && !s_q.rvalid;
  assign wr_misc = wr_go && s_axi_awaddr == `RIP_OFS_MISC && s_axi_wstrb[0];
  assign psel_refused = wr_misc && !cnd_i_mask;
  assign local_en_wr  = rip_apply_be({12'h000, s_q.local_en}, s_axi_wdata, s_axi_wstrb);

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !s_q.rvalid;

  rip_rx_flag u_rx_flag (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set_pulse (ser_rx_set),
    .status_rd (ser_status_rd),
    .data_rd   (ser_data_rd),
    .rx_full   (receive_full_flag),
    .auto_clr  (rx_auto_clr)
  );

  // Five serial comms conditions share one vector
  assign ser_any = ((receive_full_flag || ser_overrun) && s_q.local_en[`RIP_EN_RX])
                 || (ser_tx_empty && s_q.local_en[`RIP_EN_TX])
                 || (ser_tx_done && s_q.local_en[`RIP_EN_TXDN])
                 || (ser_idle && s_q.local_en[`RIP_EN_IDLE]);

  assign m_pend[0]  = !irq_pin_n;
  assign m_pend[14] = ser_any;

  genvar g;
  generate
    for (g = 1; g < 14; g++) begin : g_local
      assign m_pend[g] = periph_flag[g-1] && s_q.local_en[g-1];
    end
  endgenerate

  assign m_qual = cnd_i_mask ? 15'h0000 : m_pend;
  assign top_idx = rip_psel_to_idx(s_q.misc[3:0]);

  rip_mask_arb #(
    .N (`RIP_NUM_MASKABLE)
  ) u_arb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pend    (m_qual),
    .top_idx (top_idx),
    .hit     (m_hit),
    .idx     (m_idx)
  );

  assign nm_qual[0] = reset_req;
  assign nm_qual[1] = clock_monitor_fail && s_q.ctrl[`RIP_CTRL_CMON];
  assign nm_qual[2] = watchdog_reset && !s_q.ctrl[`RIP_CTRL_WDOG_DIS];
  assign nm_qual[3] = !nonmaskable_request_pin_n && !cnd_x_mask;
  assign nm_qual[4] = illegal_opcode;
  assign nm_qual[5] = software_trap;

  assign ev[`RIP_ST_REFUSED] = psel_refused;
  assign ev[`RIP_ST_RX_CLR]  = rx_auto_clr;

  always_comb begin
    s_d = s_q;
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    if (wr_go) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = `RIP_RESP_OKAY;
      unique case (s_axi_awaddr)
        `RIP_OFS_MISC: begin
          if (s_axi_wstrb[0]) begin
            if (s_q.misc[`RIP_MISC_SPCL]) begin
              s_d.misc[7:5] = s_axi_wdata[7:5];
            end
            s_d.misc[`RIP_MISC_VIS] = s_axi_wdata[4];
            if (cnd_i_mask) begin
              s_d.misc[3:0] = s_axi_wdata[3:0];
            end
          end
        end
        `RIP_OFS_CTRL: begin
          if (s_axi_wstrb[0]) begin
            s_d.ctrl = s_axi_wdata[1:0];
          end
        end
        `RIP_OFS_LOCAL_EN: begin
          s_d.local_en = local_en_wr[19:0];
        end
        `RIP_OFS_INT_EN: begin
          if (s_axi_wstrb[0]) begin
            s_d.int_en = s_axi_wdata[2:0];
          end
        end
        `RIP_OFS_STATUS: begin
        end
        `RIP_OFS_CLEAR: begin
          if (s_axi_wstrb[0]) begin
            s_d.status = s_q.status & ~s_axi_wdata[2:0];
          end
        end
        default: begin
          s_d.bresp = `RIP_RESP_SLVERR;
        end
      endcase
    end
    // Boot ROM bit only lives in special modes
    s_d.misc[`RIP_MISC_BROM] = s_d.misc[`RIP_MISC_BROM] && s_d.misc[`RIP_MISC_SPCL];

    // Mode pins caught in the first cycle after reset release
    if (!s_q.captured) begin
      s_d.captured = 1'b1;
      s_d.misc[`RIP_MISC_SPCL]   = !mode_select_b_pin;
      s_d.misc[`RIP_MISC_MSEL_A] = mode_select_a_pin;
      s_d.misc[`RIP_MISC_BROM]   = !mode_select_b_pin && !mode_select_a_pin;
      s_d.misc[`RIP_MISC_VIS]    = !mode_select_b_pin && mode_select_a_pin;
      s_d.misc[3:0]             = `RIP_PSEL_RESET;
    end

    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `RIP_RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `RIP_OFS_MISC:     s_d.rdata = {24'h000000, s_q.misc};
        `RIP_OFS_CTRL:     s_d.rdata = {30'h00000000, s_q.ctrl};
        `RIP_OFS_LOCAL_EN: s_d.rdata = {12'h000, s_q.local_en};
        `RIP_OFS_STATUS:   s_d.rdata = {29'h00000000, s_q.status};
        `RIP_OFS_CLEAR:    s_d.rdata = 32'h0000_0000;
        `RIP_OFS_INT_EN:   s_d.rdata = {29'h00000000, s_q.int_en};
        default:           s_d.rresp = `RIP_RESP_SLVERR;
      endcase
    end

    // Resolve every cycle; non-maskable chain outranks all maskable
    s_d.req_valid   = 1'b0;
    s_d.req_nonmask = 1'b0;
    s_d.req_src     = 5'h00;
    if (m_hit) begin
      s_d.req_valid = 1'b1;
      s_d.req_src   = {1'b0, m_idx};
    end
    for (int k = 5; k >= 0; k--) begin
      if (nm_qual[k]) begin
        s_d.req_valid   = 1'b1;
        s_d.req_nonmask = 1'b1;
        s_d.req_src     = `RIP_SRC_RESET + 5'(k);
      end
    end
    s_d.req_vector = s_d.req_valid ? rip_vector_of(s_d.req_src) : 16'h0000;

    // Set wins over a clear in the same cycle
    s_d.status[1:0] = s_d.status[1:0] | ev;
    s_d.status[`RIP_ST_NEW_REQ] = s_d.status[`RIP_ST_NEW_REQ]
                                  || (s_d.req_valid && !s_q.req_valid);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q      <= '0;
      s_q.misc <= {4'h0, `RIP_PSEL_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp  = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp  = s_q.rresp;
  assign s_axi_rdata  = s_q.rdata;

  assign req_valid   = s_q.req_valid;
  assign req_nonmask = s_q.req_nonmask;
  assign req_src     = s_q.req_src;
  assign req_vector  = s_q.req_vector;

  assign boot_rom_read     = s_q.misc[`RIP_MISC_BROM];
  assign special_mode_flag = s_q.misc[`RIP_MISC_SPCL];
  assign mode_a_flag       = s_q.misc[`RIP_MISC_MSEL_A];
  // Expanded modes: visibility; single-chip/bootstrap: set bit stops the clock
  assign read_visibility_only = s_q.misc[`RIP_MISC_VIS] && s_q.misc[`RIP_MISC_MSEL_A];
  assign bus_clock_out_en = s_q.misc[`RIP_MISC_MSEL_A] || !s_q.misc[`RIP_MISC_VIS];

  assign irq_out = |(s_q.status & s_q.int_en);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_first: assert property (reset_req |=> req_valid && req_vector == `RIP_VEC_RESET)
    else $error("reset source not ranked first");
  a_nmi_over_mask: assert property (
    !reset_req && !nm_qual[1] && !nm_qual[2] && nm_qual[3] |=> req_vector == `RIP_VEC_NMPN)
    else $error("nonmaskable pin outranked");
  a_global_mask: assert property (cnd_i_mask && nm_qual == '0 |=> !req_valid)
    else $error("maskable source passed global mask");
  a_vector_fixed: assert property (
    req_valid |-> req_vector == rip_vector_of(req_src) && (req_nonmask == (req_src > 5'h0e)))
    else $error("vector does not match source");
  a_sci_vector: assert property (req_valid && req_src == 5'h0e |-> req_vector == 16'hffd6)
    else $error("serial comms vector wrong");
  a_psel_guard: assert property (wr_misc && !cnd_i_mask && s_q.captured
                                 |=> s_q.misc[3:0] == $past(s_q.misc[3:0]))
    else $error("priority field written while unmasked");
  a_psel_refused_flag: assert property (psel_refused |=> s_q.status[`RIP_ST_REFUSED])
    else $error("refused write not flagged");
  a_boot_rom_read_zero: assert property (!special_mode_flag |-> !boot_rom_read)
    else $error("boot ROM bit set outside special mode");
  a_mode_capture: assert property ($rose(s_q.captured) |-> special_mode_flag == !$past(mode_select_b_pin)
                                   && mode_a_flag == $past(mode_select_a_pin))
    else $error("mode pins not captured");
  a_reset_value: assert property ($rose(s_q.captured) |-> s_q.misc[3:0] == `RIP_PSEL_RESET
                                  && s_q.misc[7] == (s_q.misc[6] && !s_q.misc[5])
                                  && s_q.misc[4] == (s_q.misc[6] && s_q.misc[5]))
    else $error("reset value wrong for mode");
  a_no_request: assert property (nm_qual == '0 && m_qual == '0 |=> !req_valid)
    else $error("request without qualified source");
  a_wdog_gate: assert property (
    s_q.ctrl[`RIP_CTRL_WDOG_DIS] && nm_qual[1:0] == '0 && watchdog_reset
    |=> req_vector != `RIP_VEC_WDOG)
    else $error("disabled watchdog requested");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  c_promoted: cover property (m_hit && m_qual[top_idx] && m_idx != 4'h0 && m_qual[0]);
  c_nmi: cover property (req_valid && req_src == `RIP_SRC_NMPN);
  c_refused: cover property (psel_refused);
  c_irq: cover property (irq_out);

endmodule

// ### core/rip_rx_flag.sv
`timescale 1ns/1ns
module rip_rx_flag import rip_pkg::*; (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set_pulse,
  input  wire logic status_rd,
  input  wire logic data_rd,
  output logic      rx_full,
  output logic      auto_clr
);

  rip_rx_state_t s_q;
  rip_rx_state_t s_d;

  always_comb begin
    s_d = s_q;
    auto_clr = s_q.armed && data_rd && !set_pulse;
    if (status_rd && s_q.full) begin
      s_d.armed = 1'b1;
    end
    if (s_q.armed && data_rd) begin
      s_d.armed = 1'b0;
      s_d.full  = 1'b0;
    end
    if (set_pulse) begin
      s_d.full = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_full = s_q.full;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rx_auto_clear: assert property (
    s_q.full && status_rd ##1 data_rd && !set_pulse |=> !rx_full)
    else $error("receive flag not auto-cleared");
  a_rx_set_wins: assert property (set_pulse |=> rx_full)
    else $error("receive flag set lost");
  c_rx_clear: cover property (auto_clr);

endmodule

// ### test/rip_src_model.sv
`timescale 1ns/1ns
module rip_src_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [14:0] want,
  output logic             irq_pin_n,
  output logic             nmi_pin_n,
  output logic [12:0]      flag
);
  // Pins are pulled up, so idle is high; flags follow one cycle late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pin_n <= 1'h1;
      nmi_pin_n <= 1'h1;
      flag      <= 13'h0000;
    end else begin
      irq_pin_n <= ~want[13];
      nmi_pin_n <= ~want[14];
      flag      <= want[12:0];
    end
  end
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0, req_vector;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irq_pin_n, nonmaskable_request_pin_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        mode_select_a_pin = 0, mode_select_b_pin = 1, cnd_i_mask = 1, cnd_x_mask = 1;
  logic        reset_req = 0, clock_monitor_fail = 0, watchdog_reset = 0, illegal_opcode = 0;
  logic        software_trap = 0, ser_rx_set = 0, ser_status_rd = 0, ser_data_rd = 0;
  logic        ser_overrun = 0, ser_tx_empty = 0, ser_tx_done = 0, ser_idle = 0;
  logic        receive_full_flag, req_valid, req_nonmask, read_visibility_only, irq_out;
  logic        bus_clock_out_en, boot_rom_read, special_mode_flag, mode_a_flag;
  logic [12:0] periph_flag;
  logic [4:0]  req_src;
  logic [14:0] want = 0;
  int          n_mismatch = 0, n_tests = 0;

  rip_resolver DUT (.*);
  rip_src_model far_end (.aclk(aclk), .aresetn(aresetn), .want(want), .irq_pin_n(irq_pin_n),
                         .nmi_pin_n(nonmaskable_request_pin_n), .flag(periph_flag));
  always #5 aclk = ~aclk;

  task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic ok;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin @(negedge aclk); ok = s_axi_awready & s_axi_wready; @(posedge aclk); end
    while (ok !== 1'h1);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do begin @(negedge aclk); ok = s_axi_bvalid; r = s_axi_bresp; @(posedge aclk); end
    while (ok !== 1'h1);
    s_axi_bready <= 1'h0;
    ck(r, 0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [1:0] er);
    logic ok;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin @(negedge aclk); ok = s_axi_arready; @(posedge aclk); end while (ok !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do begin @(negedge aclk); ok = s_axi_rvalid; r = s_axi_rresp; d = s_axi_rdata;
      @(posedge aclk); end
    while (ok !== 1'h1);
    s_axi_rready <= 1'h0;
    ck(r, er);
  endtask

  task automatic rq(input logic v, input logic [4:0] s, input logic [15:0] vec);
    repeat (3) @(negedge aclk);
    ck({req_valid, req_nonmask, req_src, req_vector}, {v, v & (s > 14), s, vec});
  endtask

  task automatic pl(input logic [2:0] p);
    @(posedge aclk);
    {ser_data_rd, ser_status_rd, ser_rx_set} <= p;
    @(posedge aclk);
    {ser_data_rd, ser_status_rd, ser_rx_set} <= 3'h0;
  endtask

  task automatic t_modes;
    logic [7:0] e [4];
    e = '{8'hc6, 8'h76, 8'h26, 8'h06};
    for (int m = 0; m < 4; m++) begin
      @(posedge aclk);
      aresetn <= 1'h0;
      mode_select_a_pin <= m[0] ^ m[1];
      mode_select_b_pin <= m[1];
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      rd(16'h103c, 0);
      ck(d, e[m]);
      @(negedge aclk);
      ck({boot_rom_read, special_mode_flag, mode_a_flag}, e[m][7:5]);
      ck({read_visibility_only, bus_clock_out_en}, {e[m][4] & e[m][5], e[m][5] | ~e[m][4]});
    end
  endtask

  task automatic t_misc;
    rd(16'h1054, 2'h2);
    ck(d, 0);
    wr(16'h103c, 32'hf6);
    rd(16'h103c, 0);
    ck(d, 32'h16);
    @(negedge aclk);
    ck({read_visibility_only, bus_clock_out_en}, 2'h0);
    @(posedge aclk);
    s_axi_wstrb <= 4'h0;
    wr(16'h103c, 32'h06);
    s_axi_wstrb <= 4'hf;
    rd(16'h103c, 0);
    ck(d, 32'h16);
    wr(16'h103c, 32'h06);
  endtask

  task automatic t_irq;
    @(posedge aclk);
    cnd_i_mask <= 1'h0;
    wr(16'h104c, 32'h7);
    wr(16'h1050, 32'h1);
    wr(16'h103c, 32'h07);
    rd(16'h103c, 0);
    ck(d, 32'h06);
    rd(16'h1048, 0);
    ck({d[0], irq_out}, 2'h3);
    wr(16'h1050, 32'h0);
    ck(irq_out, 0);
    wr(16'h1050, 32'h1);
    wr(16'h104c, 32'h1);
    ck(irq_out, 0);
  endtask

  task automatic t_prio;
    logic [4:0] e;
    wr(16'h1044, 32'h000f1fff);
    for (int k = 0; k < 15; k++) begin
      @(posedge aclk);
      want <= {1'h0, k == 0, 13'(13'h1fff << (k > 0 ? k - 1 : 0))};
      ser_tx_empty <= 1'h1;
      rq(1, 5'(k), 16'hfff2 - 16'(2 * k));
    end
    @(posedge aclk);
    want <= 15'h3fff;
    for (int c = 0; c < 16; c++) begin
      e = 5'(c < 5 ? c + 10 : (c < 7 ? 0 : c - 6));
      @(posedge aclk);
      cnd_i_mask <= 1'h1;
      wr(16'h103c, 32'(c));
      @(posedge aclk);
      cnd_i_mask <= 1'h0;
      rq(1, e, 16'hfff2 - {10'h000, e, 1'h0});
    end
  endtask

  task automatic t_gate;
    @(posedge aclk);
    want <= 15'h0100;
    ser_tx_empty <= 1'h0;
    cnd_i_mask <= 1'h1;
    rq(0, 0, 0);
    @(posedge aclk);
    cnd_i_mask <= 1'h0;
    rq(1, 9, 16'hffe0);
    wr(16'h1044, 32'h000f1eff);
    rq(0, 0, 0);
    @(posedge aclk);
    want <= 15'h2000;
    rq(1, 0, 16'hfff2);
  endtask

  task automatic t_rx;
    pl(3'h1);
    pl(3'h4);
    ck(receive_full_flag, 1);
    @(posedge aclk);
    ser_status_rd <= 1'h1;
    @(posedge aclk);
    {ser_data_rd, ser_status_rd} <= 2'h2;
    @(posedge aclk);
    ser_data_rd <= 1'h0;
    @(negedge aclk);
    ck(receive_full_flag, 0);
    rd(16'h1048, 0);
    ck(d[1], 1);
  endtask

  task automatic t_nmi;
    @(posedge aclk);
    cnd_i_mask <= 1'h1;
    cnd_x_mask <= 1'h1;
    software_trap <= 1'h1;
    rq(1, 20, 16'hfff6);
    @(posedge aclk);
    illegal_opcode <= 1'h1;
    want <= 15'h6000;
    rq(1, 19, 16'hfff8);
    @(posedge aclk);
    cnd_x_mask <= 1'h0;
    rq(1, 18, 16'hfff4);
    wr(16'h1040, 32'h2);
    @(posedge aclk);
    watchdog_reset <= 1'h1;
    rq(1, 18, 16'hfff4);
    wr(16'h1040, 32'h0);
    rq(1, 17, 16'hfffa);
    @(posedge aclk);
    clock_monitor_fail <= 1'h1;
    rq(1, 17, 16'hfffa);
    wr(16'h1040, 32'h1);
    rq(1, 16, 16'hfffc);
    @(posedge aclk);
    reset_req <= 1'h1;
    rq(1, 15, 16'hfffe);
  endtask

  initial begin
    t_modes();
    t_misc();
    t_irq();
    t_prio();
    t_gate();
    t_rx();
    t_nmi();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
endmodule
